// ### cgal_top.v
/*
  Charger guard and alert logic: supply and input comparator gating,
  soft-started charge current, accumulator and die heat limit alerts,
  APB register slave.
  Assumes comparator and telemetry inputs are synchronous to pclk.
*/
// Implementation choices: the APB interface to the registers and the register addresses.
// Behaviour
// R01 - Accum above upper limit sets flag, alert
// R02 - Accum below lower limit sets flag, alert
// R03 - Host pauses, arms lower limit after upper
// R04 - Host rearms upper, unpauses after lower
// R05 - Pause bit inhibits charging
// R06 - Charge current ramps from zero
// R07 - Constant current from charge code until voltage
// R08 - Battery voltage, charge current readable
// R09 - Input current readable
// R10 - Die heat readable, limit alarms
// R11 - Switching held until both supplies good
// R12 - Switching off on supply undervoltage
// R13 - Charge only with input headroom hysteresis
// R14 - Input overvoltage forces switches off
// R15 - Resume after input drops below release
// R16 - Thermistor code gates charging
// R17 - Accumulator saturates, never wraps
// R18 - Upper enable at bit 12, 0x0D
// R19 - Flags and alert held until cleared
`timescale 1ns/1ns
`include "cgal_defs.vh"

module cgal_top
(
  // APB
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Comparators
  input  wire        supply_rail_on_ok,
  input  wire        supply_rail_off_bad,
  input  wire        driver_supply_on_ok,
  input  wire        driver_supply_off_bad,
  input  wire        headroom_on_ok,
  input  wire        headroom_off_bad,
  input  wire        input_over_trip,
  input  wire        input_over_release,
  input  wire        battery_at_target,
  // Telemetry
  input  wire [15:0] battery_voltage,
  input  wire [15:0] charge_current,
  input  wire [15:0] input_current,
  input  wire [15:0] die_heat,
  input  wire [15:0] thermistor_ratio_code,
  input  wire [15:0] therm_lo_code,
  input  wire [15:0] therm_hi_code,
  input  wire        accum_up,
  input  wire        accum_down,
  // Power control
  output reg         switch_enable,
  output reg         top_switch_enable,
  output reg         bottom_switch_enable,
  output reg         charge_enable,
  output reg  [4:0]  charge_current_code,
  output reg         smbus_alert_n
);

  reg  [15:0] alert_enable;
  reg  [15:0] accum_upper_limit;
  reg  [15:0] accum_lower_limit;
  reg  [15:0] accum;
  reg  [15:0] die_heat_low_limit;
  reg  [15:0] die_heat_high_limit;
  reg  [4:0]  charge_current_goal;
  reg         pause;
  reg  [3:0]  flags;
  reg         supply_good;
  reg         headroom_good;
  reg         over_voltage;
  reg  [31:0] next_prdata;
  reg  [3:0]  next_flags;
  wire [4:0]  ramp_code;
  wire        ramp_at_goal;
  wire        wr;
  wire        rd;
  wire        therm_ok;
  wire        charge_ok;
  wire        mapped;
  wire [3:0]  events;

  assign wr = psel & penable & pwrite & pready;
  assign rd = psel & ~penable & ~pwrite;

  // R16 thermistor window
  assign therm_ok = (thermistor_ratio_code <= therm_lo_code) && (thermistor_ratio_code >= therm_hi_code);
  // R05 R13 charging gate
  assign charge_ok = supply_good & ~over_voltage & headroom_good & ~pause & therm_ok;

  assign mapped = (paddr == `CGAL_A_ALERT_EN) || (paddr == `CGAL_A_ACC_LO_LIM) ||
                  (paddr == `CGAL_A_ACC_HI_LIM) || (paddr == `CGAL_A_ACC_VALUE) ||
                  (paddr == `CGAL_A_CTRL) || (paddr == `CGAL_A_FLAGS) ||
                  (paddr == `CGAL_A_GOAL) || (paddr == `CGAL_A_HEAT_LO) ||
                  (paddr == `CGAL_A_HEAT_HI) || (paddr == `CGAL_A_DIE_HEAT) ||
                  (paddr == `CGAL_A_BAT_V) || (paddr == `CGAL_A_CHG_I) ||
                  (paddr == `CGAL_A_IN_I) || (paddr == `CGAL_A_THERM) ||
                  (paddr == `CGAL_A_STATUS) || (paddr == `CGAL_A_CMD);

  // R01 R02 R10 limit events
  assign events[`CGAL_B_F_UPPER]   = alert_enable[`CGAL_B_UPPER_EN] && (accum > accum_upper_limit);
  assign events[`CGAL_B_F_LOWER]   = alert_enable[`CGAL_B_LOWER_EN] && (accum < accum_lower_limit);
  assign events[`CGAL_B_F_HEAT_LO] = alert_enable[`CGAL_B_HEAT_LO_EN] && (die_heat < die_heat_low_limit);
  assign events[`CGAL_B_F_HEAT_HI] = alert_enable[`CGAL_B_HEAT_HI_EN] && (die_heat > die_heat_high_limit);

  // R19 write-one-to-clear, set wins over clear
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : gen_flag
      always @*
      begin
        if (events[g])
          next_flags[g] = 1'b1;
        else if (wr && (paddr == `CGAL_A_FLAGS) && pwdata[g])
          next_flags[g] = 1'b0;
        else
          next_flags[g] = flags[g];
      end
    end
  endgenerate

  // R08 R09 R10 read mux
  always @*
  begin
    next_prdata = 32'h00000000;
    if (paddr == `CGAL_A_ALERT_EN)
      next_prdata = {16'h0000, alert_enable};
    else if (paddr == `CGAL_A_ACC_LO_LIM)
      next_prdata = {16'h0000, accum_lower_limit};
    else if (paddr == `CGAL_A_ACC_HI_LIM)
      next_prdata = {16'h0000, accum_upper_limit};
    else if (paddr == `CGAL_A_ACC_VALUE)
      next_prdata = {16'h0000, accum};
    else if (paddr == `CGAL_A_CTRL)
      next_prdata = {31'h00000000, pause};
    else if (paddr == `CGAL_A_FLAGS)
      next_prdata = {28'h0000000, flags};
    else if (paddr == `CGAL_A_GOAL)
      next_prdata = {27'h0000000, charge_current_goal};
    else if (paddr == `CGAL_A_HEAT_LO)
      next_prdata = {16'h0000, die_heat_low_limit};
    else if (paddr == `CGAL_A_HEAT_HI)
      next_prdata = {16'h0000, die_heat_high_limit};
    else if (paddr == `CGAL_A_DIE_HEAT)
      next_prdata = {16'h0000, die_heat};
    else if (paddr == `CGAL_A_BAT_V)
      next_prdata = {16'h0000, battery_voltage};
    else if (paddr == `CGAL_A_CHG_I)
      next_prdata = {16'h0000, charge_current};
    else if (paddr == `CGAL_A_IN_I)
      next_prdata = {16'h0000, input_current};
    else if (paddr == `CGAL_A_THERM)
      next_prdata = {16'h0000, thermistor_ratio_code};
    else if (paddr == `CGAL_A_STATUS)
      next_prdata = {22'h000000, ramp_code, ramp_at_goal, charge_ok, headroom_good, over_voltage, supply_good};
  end

  // APB slave: no wait states, answer in first access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (rd)
        prdata <= next_prdata;
    end
  end

  // Writable registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alert_enable        <= `CGAL_RST_ALERT_EN;
      accum_upper_limit   <= `CGAL_RST_LIMIT_HI;
      accum_lower_limit   <= `CGAL_RST_LIMIT_LO;
      die_heat_low_limit  <= `CGAL_RST_LIMIT_LO;
      die_heat_high_limit <= `CGAL_RST_LIMIT_HI;
      charge_current_goal <= `CGAL_RST_GOAL;
      pause               <= 1'b0;
    end
    else if (clk_en && wr)
    begin
      // R18 upper enable held at bit 12
      if (paddr == `CGAL_A_ALERT_EN)
        alert_enable <= pwdata[15:0];
      else if (paddr == `CGAL_A_ACC_LO_LIM)
        accum_lower_limit <= pwdata[15:0];
      else if (paddr == `CGAL_A_ACC_HI_LIM)
        accum_upper_limit <= pwdata[15:0];
      else if (paddr == `CGAL_A_CTRL)
        pause <= pwdata[`CGAL_B_PAUSE];
      else if (paddr == `CGAL_A_GOAL)
        charge_current_goal <= pwdata[4:0];
      else if (paddr == `CGAL_A_HEAT_LO)
        die_heat_low_limit <= pwdata[15:0];
      else if (paddr == `CGAL_A_HEAT_HI)
        die_heat_high_limit <= pwdata[15:0];
    end
  end

  // Accumulator and flags
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      accum <= `CGAL_ACC_MIN;
      flags <= 4'h0;
    end
    else if (clk_en)
    begin
      flags <= next_flags;
      if (wr && (paddr == `CGAL_A_ACC_VALUE))
        accum <= pwdata[15:0];
      // R17 saturating count
      else if ((accum_up || (wr && (paddr == `CGAL_A_CMD) && (pwdata[1:0] == `CGAL_CMD_INC)))
               && (accum != `CGAL_ACC_MAX))
        accum <= accum + 16'h0001;
      else if ((accum_down || (wr && (paddr == `CGAL_A_CMD) && (pwdata[1:0] == `CGAL_CMD_DEC)))
               && (accum != `CGAL_ACC_MIN))
        accum <= accum - 16'h0001;
    end
  end

  // Hysteresis latches and power outputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      supply_good          <= 1'b0;
      headroom_good        <= 1'b0;
      over_voltage         <= 1'b0;
      switch_enable        <= 1'b0;
      top_switch_enable    <= 1'b0;
      bottom_switch_enable <= 1'b0;
      charge_enable        <= 1'b0;
      charge_current_code  <= 5'h00;
      smbus_alert_n        <= 1'b1;
    end
    else if (clk_en)
    begin
      // R12 undervoltage turns controller off
      if (supply_rail_off_bad || driver_supply_off_bad)
        supply_good <= 1'b0;
      // R11 both supplies above start levels
      else if (supply_rail_on_ok && driver_supply_on_ok)
        supply_good <= 1'b1;
      // R13 headroom hysteresis
      if (headroom_off_bad)
        headroom_good <= 1'b0;
      else if (headroom_on_ok)
        headroom_good <= 1'b1;
      // R14 trip latches overvoltage
      if (input_over_trip)
        over_voltage <= 1'b1;
      // R15 release below lower threshold
      else if (input_over_release)
        over_voltage <= 1'b0;
      switch_enable        <= supply_good & ~over_voltage;
      top_switch_enable    <= supply_good & ~over_voltage & charge_ok;
      bottom_switch_enable <= supply_good & ~over_voltage & charge_ok;
      charge_enable        <= charge_ok;
      // R07 constant current code until target voltage
      charge_current_code  <= battery_at_target ? 5'h00 : ramp_code;
      // R01 R02 R19 alert held while any flag set
      smbus_alert_n        <= ~(|flags);
    end
  end

  // R06 soft-start ramp
  cgal_soft_start u_ramp
  (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .enable  (charge_ok),
    .goal    (charge_current_goal),
    .code    (ramp_code),
    .at_goal (ramp_at_goal)
  );

endmodule

// ### cgal_defs.vh
/*
  Constants for the charger guard and alert logic: APB register map,
  field positions, reset values and soft-start timing.
  Assumes a 10 MHz pclk and 32-bit APB data.
*/
`ifndef CGAL_DEFS_VH
`define CGAL_DEFS_VH

// Register byte addresses (printed index times four where printed)
`define CGAL_IDX_ALERT_EN        8'h0D
`define CGAL_IDX_ACC_LO_LIM      8'h10
`define CGAL_IDX_ACC_HI_LIM      8'h11
`define CGAL_IDX_ACC_VALUE       8'h13
`define CGAL_A_ALERT_EN          12'h034
`define CGAL_A_ACC_LO_LIM        12'h040
`define CGAL_A_ACC_HI_LIM        12'h044
`define CGAL_A_ACC_VALUE         12'h04C
`define CGAL_A_CTRL              12'h080
`define CGAL_A_FLAGS             12'h084
`define CGAL_A_GOAL              12'h088
`define CGAL_A_HEAT_LO           12'h08C
`define CGAL_A_HEAT_HI           12'h090
`define CGAL_A_DIE_HEAT          12'h094
`define CGAL_A_BAT_V             12'h098
`define CGAL_A_CHG_I             12'h09C
`define CGAL_A_IN_I              12'h0A0
`define CGAL_A_THERM             12'h0A4
`define CGAL_A_STATUS            12'h0A8
`define CGAL_A_CMD               12'h0AC

// Alert enable register bits
`define CGAL_B_UPPER_EN          12
`define CGAL_B_LOWER_EN          13
`define CGAL_B_HEAT_LO_EN        0
`define CGAL_B_HEAT_HI_EN        1
// Control register bits
`define CGAL_B_PAUSE             0
// Flag bits
`define CGAL_B_F_UPPER           0
`define CGAL_B_F_LOWER           1
`define CGAL_B_F_HEAT_LO         2
`define CGAL_B_F_HEAT_HI         3

// Reset values
`define CGAL_RST_ALERT_EN        16'h0000
`define CGAL_RST_LIMIT_HI        16'hFFFF
`define CGAL_RST_LIMIT_LO        16'h0000
`define CGAL_RST_GOAL            5'h1F
`define CGAL_ACC_MIN             16'h0000
`define CGAL_ACC_MAX             16'hFFFF

// Soft-start: one code step every STEP_US microseconds
`define CGAL_CLK_MHZ             10
`define CGAL_SS_STEP_US          100
`define CGAL_SS_STEP_CYC         (`CGAL_SS_STEP_US * `CGAL_CLK_MHZ)
// Last tick of a step, one below STEP_CYC, sized for the tick counter
`define CGAL_SS_TICK_LAST        11'h3E7

// Accumulator command codes (write to CMD register)
`define CGAL_CMD_INC             2'h1
`define CGAL_CMD_DEC             2'h2

`endif

// ### cgal_soft_start.v
/*
  Soft-start ramp for the charge current code.
  Assumes enable is a level from the guard logic in the same clock domain.
*/
`timescale 1ns/1ns
`include "cgal_defs.vh"

module cgal_soft_start
(
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  input  wire       clk_en,
  // Control
  input  wire       enable,
  input  wire [4:0] goal,
  // Result
  output reg  [4:0] code,
  output reg        at_goal
);

  reg [10:0] tick;

  // Step toward goal; restart from zero whenever charging drops
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick    <= 11'h000;
      code    <= 5'h00;
      at_goal <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!enable)
      begin
        tick    <= 11'h000;
        code    <= 5'h00;
        at_goal <= 1'b0;
      end
      else
      begin
        at_goal <= (code == goal);
        if (tick == `CGAL_SS_TICK_LAST)
        begin
          tick <= 11'h000;
          if (code < goal)
            code <= code + 5'h01;
          else if (code > goal)
            code <= goal;
        end
        else
          tick <= tick + 11'h001;
      end
    end
  end

endmodule

// ### cgal_monitor.sv
/*
  Checker for the charger guard block: APB answer timing, power gating,
  soft-start steps and alert hold.
  Assumes one pclk domain, presetn active low, bound to cgal_top.
*/
`timescale 1ns/1ns

module cgal_monitor
(
  // APB
  input wire       pclk,
  input wire       presetn,
  input wire       clk_en,
  input wire       psel,
  input wire       penable,
  input wire       pwrite,
  input wire       pready,
  input wire       pslverr,
  // Guard
  input wire       supply_rail_off_bad,
  input wire       headroom_off_bad,
  input wire       input_over_trip,
  input wire       battery_at_target,
  input wire       switch_enable,
  input wire       top_switch_enable,
  input wire       bottom_switch_enable,
  input wire       charge_enable,
  input wire [4:0] charge_current_code,
  input wire       smbus_alert_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_after_setup:
    assert property (psel && !penable && clk_en |=> pready) else $error("no ready after setup");
  a_ready_one_cycle:
    assert property (pready |=> !pready) else $error("ready held too long");
  a_idle_no_ready:
    assert property (!psel |=> !pready) else $error("ready without select");
  a_error_with_ready:
    assert property (pslverr |-> pready) else $error("error without ready");
  a_overvolt_off:
    assert property (input_over_trip |-> ##2 !top_switch_enable && !bottom_switch_enable) else $error("switch in overvolt");
  a_uvlo_off:
    assert property (supply_rail_off_bad |-> ##2 !switch_enable) else $error("switching on low supply");
  a_headroom_off:
    assert property (headroom_off_bad |-> ##2 !charge_enable) else $error("charging without headroom");
  a_ramp_from_zero:
    assert property ($rose(charge_enable) |-> charge_current_code == 5'h00) else $error("ramp not from zero");
  a_ramp_one_step:
    assert property (!$past(battery_at_target, 2) |->
                     {1'b0, charge_current_code} <= {1'b0, $past(charge_current_code)} + 6'h01)
      else $error("ramp jumped");
  a_alert_holds:
    assert property (!smbus_alert_n && !(psel && penable && pwrite) &&
                     !($past(psel) && $past(penable) && $past(pwrite)) |=> !smbus_alert_n)
      else $error("alert dropped without clear");

  cover property (pslverr);
  cover property ($fell(smbus_alert_n));
  cover property ($rose(charge_enable));
endmodule

bind cgal_top cgal_monitor i_cgal_monitor
(
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .supply_rail_off_bad(supply_rail_off_bad),
  .headroom_off_bad(headroom_off_bad), .input_over_trip(input_over_trip),
  .battery_at_target(battery_at_target), .switch_enable(switch_enable), .top_switch_enable(top_switch_enable),
  .bottom_switch_enable(bottom_switch_enable), .charge_enable(charge_enable),
  .charge_current_code(charge_current_code), .smbus_alert_n(smbus_alert_n)
);

// ### cgal_accum_src.sv
/*
  Accumulator tick source standing in for the charge integrator.
  Assumes requests from the bench, synchronous to pclk.
*/
`timescale 1ns/1ns

module cgal_accum_src
(
  // Clock
  input wire pclk,
  input wire presetn,
  // Requests
  input wire up_req,
  input wire dn_req,
  // Ticks
  output reg accum_up,
  output reg accum_down
);
  // One tick every other cycle, as a prescaler gives
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      accum_up   <= 1'b0;
      accum_down <= 1'b0;
    end
    else
    begin
      accum_up   <= up_req & ~accum_up;
      accum_down <= dn_req & ~accum_down;
    end
  end
endmodule

// ### cgal_top_tb.sv
/*
  Self-checking bench for cgal_top: APB host tasks and sequences.
  Assumes the tick source model and the checker bound to cgal_top.
*/
`timescale 1ns/1ns
`include "cgal_defs.vh"

module cgal_top_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rerr, up_req = 1'b0, dn_req = 1'b0, acc_up, acc_dn;
  logic        r_on = 1'b0, r_off = 1'b0, d_on = 1'b0, d_off = 1'b0, h_on = 1'b0, h_off = 1'b0;
  logic        trip = 1'b0, rel = 1'b0, at_tgt = 1'b0, en = 1'b1, sw, top, bot, chg, alert_n;
  logic [15:0] bat_v = 16'h0, chg_i = 16'h0, in_i = 16'h0, heat = 16'h0, ratio = 16'h8000;
  logic [15:0] t_lo = 16'hFFFF, t_hi = 16'h0000;
  logic [4:0]  code;
  int          errors = 0, n_checks = 0, cycles = 0;

  always #50 pclk = ~pclk;

  cgal_accum_src i_cgal_accum_src
  (.pclk(pclk), .presetn(presetn), .up_req(up_req), .dn_req(dn_req), .accum_up(acc_up), .accum_down(acc_dn));

  cgal_top i_cgal_top
  (
    .pclk(pclk), .presetn(presetn), .clk_en(en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_rail_on_ok(r_on), .supply_rail_off_bad(r_off), .driver_supply_on_ok(d_on),
    .driver_supply_off_bad(d_off), .headroom_on_ok(h_on), .headroom_off_bad(h_off),
    .input_over_trip(trip), .input_over_release(rel), .battery_at_target(at_tgt),
    .battery_voltage(bat_v), .charge_current(chg_i), .input_current(in_i), .die_heat(heat),
    .thermistor_ratio_code(ratio), .therm_lo_code(t_lo), .therm_hi_code(t_hi), .accum_up(acc_up),
    .accum_down(acc_dn), .switch_enable(sw), .top_switch_enable(top), .bottom_switch_enable(bot),
    .charge_enable(chg), .charge_current_code(code), .smbus_alert_n(alert_n)
  );

  task give_verdict;
    $display("checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One transfer, held until pready, then one idle cycle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  task pulse(input logic up, input int n);
    up_req <= up;
    dn_req <= ~up;
    cyc(n);
    up_req <= 1'b0;
    dn_req <= 1'b0;
    cyc(3);
  endtask

  always @(posedge pclk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      errors = errors + 1;
      give_verdict;
    end
  end

  initial
  begin
    cyc(16);
    presetn <= 1'b1;
    cyc(1);
    rd(`CGAL_A_ALERT_EN, 32'h0);
    rd(`CGAL_A_ACC_HI_LIM, 32'hFFFF);
    rd(`CGAL_A_ACC_LO_LIM, 32'h0);
    rd(`CGAL_A_GOAL, 32'h1F);
    rd(`CGAL_A_HEAT_HI, 32'hFFFF);
    rd(`CGAL_A_FLAGS, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0);
    chkb(rerr, 1'b1);
    chk(rdat, 32'h0);
    bat_v <= 16'h1234;
    chg_i <= 16'h0567;
    in_i  <= 16'h89AB;
    heat  <= 16'h0200;
    wr(`CGAL_A_HEAT_HI, 32'h0100);
    rd(`CGAL_A_BAT_V, 32'h1234);
    rd(`CGAL_A_CHG_I, 32'h0567);
    rd(`CGAL_A_IN_I, 32'h89AB);
    rd(`CGAL_A_DIE_HEAT, 32'h0200);
    wr(`CGAL_A_ALERT_EN, 32'h0002);
    cyc(10);
    chkb(alert_n, 1'b0);
    rd(`CGAL_A_FLAGS, 32'h8);
    wr(`CGAL_A_ALERT_EN, 32'h0);
    wr(`CGAL_A_FLAGS, 32'h8);
    cyc(1);
    chkb(alert_n, 1'b1);
    // Power up sequence
    r_on <= 1'b1;
    cyc(5);
    chkb(sw, 1'b0);
    d_on <= 1'b1;
    cyc(5);
    chkb(sw, 1'b1);
    chkb(chg, 1'b0);
    h_on <= 1'b1;
    cyc(5);
    chkb(chg, 1'b1);
    cyc(500);
    chk({27'h0, code}, 32'h0);
    cyc(600);
    chk({27'h0, code}, 32'h1);
    at_tgt <= 1'b1;
    cyc(4);
    chk({27'h0, code}, 32'h0);
    at_tgt <= 1'b0;
    cyc(4);
    chk({27'h0, code}, 32'h1);
    wr(`CGAL_A_CTRL, 32'h1);
    cyc(2);
    chkb(chg, 1'b0);
    chk({27'h0, code}, 32'h0);
    wr(`CGAL_A_CTRL, 32'h0);
    cyc(2);
    chkb(chg, 1'b1);
    h_on  <= 1'b0;
    h_off <= 1'b1;
    cyc(4);
    chkb(chg, 1'b0);
    h_off <= 1'b0;
    cyc(4);
    chkb(chg, 1'b0);
    h_on <= 1'b1;
    t_lo <= 16'h7000;
    cyc(4);
    chkb(chg, 1'b0);
    t_lo <= 16'hFFFF;
    cyc(4);
    chkb(chg, 1'b1);
    trip <= 1'b1;
    cyc(4);
    trip <= 1'b0;
    chkb(bot, 1'b0);
    cyc(4);
    chkb(top, 1'b0);
    rel <= 1'b1;
    cyc(4);
    chkb(top, 1'b1);
    rel   <= 1'b0;
    r_on  <= 1'b0;
    r_off <= 1'b1;
    d_off <= 1'b1;
    cyc(4);
    chkb(sw, 1'b0);
    r_off <= 1'b0;
    d_off <= 1'b0;
    r_on  <= 1'b1;
    // Capacity termination round trip
    wr(`CGAL_A_ACC_VALUE, 32'h00FF);
    wr(`CGAL_A_ACC_HI_LIM, 32'h0100);
    wr(`CGAL_A_ALERT_EN, 32'h1000);
    pulse(1'b1, 4);
    cyc(10);
    chkb(alert_n, 1'b0);
    rd(`CGAL_A_FLAGS, 32'h1);
    wr(`CGAL_A_CTRL, 32'h1);
    wr(`CGAL_A_ACC_LO_LIM, 32'h00F3);
    wr(`CGAL_A_ALERT_EN, 32'h2000);
    chkb(alert_n, 1'b0);
    wr(`CGAL_A_FLAGS, 32'h1);
    cyc(1);
    chkb(alert_n, 1'b1);
    wr(`CGAL_A_ACC_VALUE, 32'h00F4);
    pulse(1'b0, 4);
    cyc(10);
    chkb(alert_n, 1'b0);
    rd(`CGAL_A_FLAGS, 32'h2);
    wr(`CGAL_A_ALERT_EN, 32'h1000);
    wr(`CGAL_A_CTRL, 32'h0);
    wr(`CGAL_A_FLAGS, 32'h2);
    cyc(1);
    chkb(alert_n, 1'b1);
    chkb(chg, 1'b1);
    wr(`CGAL_A_ACC_VALUE, 32'hFFFF);
    pulse(1'b1, 4);
    rd(`CGAL_A_ACC_VALUE, 32'hFFFF);
    wr(`CGAL_A_ACC_VALUE, 32'h0001);
    pulse(1'b0, 6);
    rd(`CGAL_A_ACC_VALUE, 32'h0);
    // Frozen clock enable ignores counts
    en <= 1'b0;
    pulse(1'b1, 4);
    en <= 1'b1;
    rd(`CGAL_A_ACC_VALUE, 32'h0);
    wr(`CGAL_A_CMD, {30'h0, `CGAL_CMD_INC});
    rd(`CGAL_A_ACC_VALUE, 32'h1);
    wr(`CGAL_A_HEAT_LO, 32'h0300);
    wr(`CGAL_A_ALERT_EN, 32'h0001);
    rd(`CGAL_A_FLAGS, 32'h5);
    rd(`CGAL_A_STATUS, 32'hD);
    give_verdict;
  end
endmodule
